// ### dv/card_voltage_class_selection_bench.sv
// Purpose: self-checking bench of the supply class sequencer
// Assumes: waits shortened to 4/4/200/4 cycles
// Notes: each run resets and plays one answer table
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin mismatches++; $display("unexpected %s expected %h seen %h", n, e, s); end end
module card_voltage_class_selection_bench;
    import cvs_pkg::*;
    logic clk = 0, rst = 1;
    logic [4:0] stb = 5'h00; // start, select, indication, access, command from bit 0
    logic ven, cen, rst_n, rdy, rej, asel;
    logic [4:0] term = 5'h07, mask = 5'h04, vcls, ccls, first;
    logic [9:0] pind = 10'h000, lim;
    logic [15:0] seq = 16'h0000;
    logic [31:0] lf = 32'hda626ab7;
    cvs_atr_byte_t atr;
    int mismatches = 0, checked = 0, cyc = 0, tries = 0;
    logic [4:0] tbl [6] = '{5'h01, 5'h02, 5'h04, 5'h03, 5'h06, 5'h07};
    cvs_seq #(.PWR_SETTLE(4), .RST_HOLD(4), .ATR_WAIT(200), .DEACT_WAIT(4)) u_cvs_seq (
        .mclk_in(clk), .sys_rst_in(rst), .start_in(stb[0]), .term_classes_in(term),
        .atr_byte_in(atr), .app_select_in(stb[1]), .access_ok_in(stb[3]), .app_cmd_in(stb[4]),
        .power_ind_valid_in(stb[2]), .power_ind_in(pind), .vcc_en_out(ven),
        .vcc_class_out(vcls), .card_clk_en_out(cen), .card_rst_n_out(rst_n),
        .link_ready_out(rdy), .card_rejected_out(rej), .card_classes_out(ccls),
        .app_selected_out(asel), .current_limit_out(lim));
    cvs_card_model u_cvs_card_model (.mclk_in(clk), .sys_rst_in(rst), .vcc_en_in(ven),
        .card_rst_n_in(rst_n), .mode_seq_in(seq), .mask_in(mask), .atr_out(atr));
    initial forever #10 clk = ~clk;
    always @(posedge ven) begin
        #1;
        if (tries == 0) first = vcls;
        tries++;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], 1'b0} ^ (v[31] ? 32'h04c11db7 : 32'h0);
    endfunction
    function automatic logic [4:0] hb(input logic [4:0] v);
        return v[2] ? CLASS_C : v[1] ? CLASS_B : v[0] ? CLASS_A : CLASS_NONE;
    endfunction
    task automatic pulse(input logic [4:0] k);
        @(posedge clk) stb <= k;
        @(posedge clk) stb <= 5'h00;
    endtask
    task automatic run(input logic [4:0] t, input logic [15:0] s, input logic [4:0] m,
            input logic [4:0] ec, input int en);
        int w;
        @(posedge clk) rst <= 1'b1;
        term <= t;
        seq <= s;
        mask <= m;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        tries = 0;
        pulse(5'h01);
        for (w = 0; w < 5000 && rdy !== 1'b1 && rej !== 1'b1; w++) @(negedge clk);
        `CHK("rejected", ec == 5'h00, rej)
        `CHK("attempts", en, tries)
        `CHK("first", hb(t), first)
        if (ec != 5'h00) `CHK("class", ec, vcls)
        if (ec != 5'h00) `CHK("mask", m, ccls)
    endtask
    task automatic app(input logic v, input logic [9:0] p, input logic [9:0] e);
        pulse(5'h02);
        if (v) @(posedge clk) pind <= p;
        if (v) pulse(5'h04);
        repeat (2) @(negedge clk);
        `CHK("limit", ATR_MAX_C, lim)
        pulse(v ? 5'h08 : 5'h10);
        repeat (2) @(negedge clk);
        `CHK("selected", 1'b1, asel)
        `CHK("limit", e, lim)
    endtask
    task automatic tally_and_finish();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            mismatches++;
            tally_and_finish();
        end
    end
    initial begin
        logic [4:0] t, m, c, e;
        run(5'h07, 16'h0000, 5'h04, CLASS_C, 1);
        app(1'b1, 10'h0c8, 10'h0c8);
        app(1'b1, 10'h3ff, SESS_MAX_C);
        app(1'b0, 10'h000, SESS_DEFAULT);
        run(5'h07, 16'h0000, 5'h01, CLASS_A, 2);
        run(5'h07, 16'h0001, 5'h02, CLASS_B, 2);
        run(5'h07, 16'h002a, 5'h06, CLASS_B, 4);
        run(5'h07, 16'h006a, 5'h01, CLASS_A, 5);
        run(5'h04, 16'h002a, 5'h04, CLASS_NONE, 3);
        run(5'h04, 16'h0001, 5'h04, CLASS_NONE, 1);
        for (int i = 0; i < 8; i++) begin
            lf = lfsr(lf);
            t = (lf[2:0] == 3'h0) ? 5'h07 : {lf[4:3], lf[2:0]};
            m = tbl[lf[10:8] % 6];
            c = hb(t);
            e = ((m & c) != 5'h00) ? c : hb(m & t);
            run(t, 16'h0000, m, e, ((m & c) != 5'h00 || e == 5'h00) ? 1 : 2);
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire

// ### dv/cvs_card_model.sv
// Purpose: card answering reset with a fixed byte string
// Assumes: mode per attempt, 2 bits each: 0 clean, 1 silent, 2 corrupt
// Notes: idle data is the inverse of the last byte
`timescale 1ns/1ns
`default_nettype none
module cvs_card_model (
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input wire logic vcc_en_in,
    input wire logic card_rst_n_in,
    input wire logic [15:0] mode_seq_in,
    input wire logic [4:0] mask_in,
    output cvs_pkg::cvs_atr_byte_t atr_out
);
    import cvs_pkg::*;
    logic [3:0] idx;
    logic [1:0] gap, mode;
    logic [2:0] n;
    logic rst_q, fire;
    logic [7:0] last, b;
    // T=1 and T=15 groups, class in third TA, one historical, check byte
    always_comb begin
        case (idx)
            4'h1: b = TS_DIRECT;
            4'h2: b = 8'h81;
            4'h3: b = 8'h81;
            4'h4: b = 8'h1f;
            4'h5: b = {3'h0, mask_in};
            4'h6: b = 8'h80;
            default: b = 8'h9f ^ {3'h0, mask_in};
        endcase
    end
    assign fire = !sys_rst_in && card_rst_n_in && vcc_en_in && rst_q && idx != 4'h0
        && mode != 2'h1 && gap == 2'h3;
    // answer starts at each reset release
    always_ff @(posedge mclk_in) begin
        rst_q <= card_rst_n_in;
        atr_out <= fire ? {1'b1, mode == 2'h2 && idx == 4'h3, b} : {2'b00, ~last};
        if (sys_rst_in) begin
            n <= 3'h0;
            idx <= 4'h0;
            last <= 8'h00;
        end else if (!card_rst_n_in || !vcc_en_in) begin
            idx <= 4'h0;
        end else if (!rst_q) begin
            mode <= mode_seq_in[2 * n +: 2];
            n <= n + 3'h1;
            idx <= 4'h1;
            gap <= 2'h0;
        end else if (idx != 4'h0 && mode != 2'h1) begin
            gap <= gap + 2'h1;
            if (gap == 2'h3) begin
                last <= b;
                idx <= (idx == 4'h7) ? 4'h0 : idx + 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

// ### dv/cvs_seq_assertions.sv
// Purpose: port-level checks of the supply class sequencer
// Assumes: one clock, synchronous reset
// Notes: bound into cvs_seq
`timescale 1ns/1ns
`default_nettype none
module cvs_seq_assertions
    import cvs_pkg::*;
#(
    parameter int PWR_SETTLE = 4,
    parameter int RST_HOLD = 4
) (
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input wire logic access_ok_in,
    input wire logic app_cmd_in,
    input wire logic vcc_en_out,
    input wire logic [4:0] vcc_class_out,
    input wire logic card_clk_en_out,
    input wire logic card_rst_n_out,
    input wire logic link_ready_out,
    input wire logic card_rejected_out,
    input wire logic app_selected_out,
    input wire logic [9:0] current_limit_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (sys_rst_in);
    ready_needs_power_a: assert property (
        link_ready_out |-> vcc_en_out && card_rst_n_out) else $error("ready unpowered");
    clk_after_supply_a: assert property (
        $rose(card_clk_en_out) |-> $past(vcc_en_out, PWR_SETTLE + 1)
        && !$past(vcc_en_out, PWR_SETTLE + 2)) else $error("clock timing");
    rst_after_clk_a: assert property (
        $rose(card_rst_n_out) |-> $past(card_clk_en_out, RST_HOLD + 1)
        && !$past(card_clk_en_out, RST_HOLD + 2)) else $error("reset timing");
    deact_all_low_a: assert property (
        $fell(vcc_en_out) |-> !card_clk_en_out && !card_rst_n_out) else $error("deact");
    class_legal_a: assert property (
        $onehot0(vcc_class_out) && vcc_class_out[4:3] == 2'h0) else $error("bad class");
    reject_off_a: assert property (
        card_rejected_out |-> !vcc_en_out && !link_ready_out) else $error("reject on");
    atr_limit_a: assert property (
        !app_selected_out && $stable(app_selected_out) && $stable(vcc_class_out)
        && vcc_class_out != 5'h00 |-> current_limit_out == (vcc_class_out == CLASS_A ?
        ATR_MAX_A : vcc_class_out == CLASS_B ? ATR_MAX_B : ATR_MAX_C)) else $error("limit");
    select_cause_a: assert property (
        $rose(app_selected_out) |-> $past(access_ok_in) || $past(app_cmd_in))
        else $error("selected");
endmodule
bind cvs_seq cvs_seq_assertions #(.PWR_SETTLE(PWR_SETTLE), .RST_HOLD(RST_HOLD)) u_chk (
    .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .access_ok_in(access_ok_in),
    .app_cmd_in(app_cmd_in), .vcc_en_out(vcc_en_out), .vcc_class_out(vcc_class_out),
    .card_clk_en_out(card_clk_en_out), .card_rst_n_out(card_rst_n_out),
    .link_ready_out(link_ready_out), .card_rejected_out(card_rejected_out),
    .app_selected_out(app_selected_out), .current_limit_out(current_limit_out));
`default_nettype wire

// ### src/cvs_atr_parse.sv
// Purpose: walks an answer-to-reset byte string and pulls out the class mask
// Assumes: bytes arrive one per valid strobe, cleared by clr_in before each attempt
// Notes: corrupt sticks until clr_in; incomplete strings are judged by the caller
`timescale 1ns/1ns
`default_nettype none
module cvs_atr_parse (
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input wire logic clr_in,
    input wire cvs_pkg::cvs_atr_byte_t byte_in,
    output cvs_pkg::cvs_atr_info_t info_out
);
    import cvs_pkg::*;

    typedef enum {PH_TS, PH_FMT, PH_IFC, PH_HIST, PH_TCK, PH_DONE} cvs_phase_t;

    cvs_phase_t phase, next_phase;
    logic [3:0] pend, next_pend;
    logic [3:0] grp, next_grp;
    logic [3:0] hist, next_hist;
    logic glob, next_glob;
    logic need_tck, next_need_tck;
    logic [7:0] xsum, next_xsum;
    cvs_atr_info_t info, next_info;

    function automatic cvs_phase_t after_ifc(input logic [3:0] p, input logic [3:0] h,
                                             input logic t);
        if (p != 4'h0) begin
            return PH_IFC;
        end else if (h != 4'h0) begin
            return PH_HIST;
        end else if (t) begin
            return PH_TCK;
        end
        return PH_DONE;
    endfunction

    always_comb begin
        logic [7:0] b;
        b = byte_in.data;
        next_phase = phase;
        next_pend = pend;
        next_grp = grp;
        next_hist = hist;
        next_glob = glob;
        next_need_tck = need_tck;
        next_xsum = xsum;
        next_info = info;
        if (clr_in) begin
            next_phase = PH_TS;
            next_info = '0;
            next_xsum = 8'h00;
            next_need_tck = 1'b0;
        end else if (byte_in.valid && phase != PH_DONE && !info.corrupt) begin
            next_info.started = 1'b1;
            if (phase != PH_TS) begin
                next_xsum = xsum ^ b;
            end
            if (byte_in.err) begin
                next_info.corrupt = 1'b1;
            end
            // every protocol accepted; a TS other than direct or inverse, a bad check byte or a TD in group 15 is corrupt
            case (phase)
                PH_TS: begin
                    if (b != TS_DIRECT && b != TS_INVERSE) begin
                        next_info.corrupt = 1'b1;
                    end
                    next_phase = PH_FMT;
                end
                PH_FMT: begin
                    next_hist = b[3:0];
                    next_pend = b[7:4];
                    next_grp = 4'h1;
                    next_glob = 1'b0;
                    next_phase = after_ifc(b[7:4], b[3:0], 1'b0);
                end
                PH_IFC: begin
                    if (pend[0]) begin
                        next_pend[0] = 1'b0;
                        // class byte: first TA after T=15, group above two
                        if (glob && grp >= GLOBAL_MIN_GRP && !info.cls_valid) begin
                            next_info.cls_valid = 1'b1;
                            next_info.cls = b[4:0];
                        end
                    end else if (pend[1]) begin
                        next_pend[1] = 1'b0;
                    end else if (pend[2]) begin
                        next_pend[2] = 1'b0;
                    end else begin
                        next_pend = b[7:4];
                        next_glob = (b[3:0] == PROT_GLOBAL);
                        next_need_tck = need_tck | (b[3:0] != 4'h0);
                        if (grp == 4'hf) begin
                            next_info.corrupt = 1'b1;
                        end
                        next_grp = grp + 4'h1;
                    end
                    next_phase = after_ifc(next_pend, hist, next_need_tck);
                end
                PH_HIST: begin
                    next_hist = hist - 4'h1;
                    next_phase = after_ifc(4'h0, next_hist, need_tck);
                end
                PH_TCK: begin
                    if ((xsum ^ b) != 8'h00) begin
                        next_info.corrupt = 1'b1;
                    end
                    next_phase = PH_DONE;
                end
                default: next_phase = PH_DONE;
            endcase
            if (next_phase == PH_DONE) begin
                next_info.done = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            phase <= PH_TS;
            pend <= 4'h0;
            grp <= 4'h0;
            hist <= 4'h0;
            glob <= 1'b0;
            need_tck <= 1'b0;
            xsum <= 8'h00;
            info <= '0;
        end else begin
            phase <= next_phase;
            pend <= next_pend;
            grp <= next_grp;
            hist <= next_hist;
            glob <= next_glob;
            need_tck <= next_need_tck;
            xsum <= next_xsum;
            info <= next_info;
        end
    end

    assign info_out = info;

endmodule
`default_nettype wire

// ### src/cvs_pkg.sv
// Purpose: shared constants and carriers of the card voltage class sequencer
// Assumes: 50 MHz system clock; answer-to-reset bytes come from a receiver on the same clock
// Notes: class mask bit 0 = A (highest voltage) ... bit 2 = C, bits 3..4 reserved
package cvs_pkg;

    localparam int CLK_MHZ = 50;
    // activation and deactivation times in microseconds
    localparam int PWR_SETTLE_US = 1000;
    localparam int RST_HOLD_US = 100;
    localparam int ATR_WAIT_US = 20000;
    localparam int DEACT_US = 1000;
    localparam int PWR_SETTLE_CYC = PWR_SETTLE_US * CLK_MHZ;
    localparam int RST_HOLD_CYC = RST_HOLD_US * CLK_MHZ;
    localparam int ATR_WAIT_CYC = ATR_WAIT_US * CLK_MHZ;
    localparam int DEACT_CYC = DEACT_US * CLK_MHZ;

    localparam int CORRUPT_TRIES = 3;
    localparam logic [4:0] CLASS_NONE = 5'h00;
    localparam logic [4:0] CLASS_A = 5'h01;
    localparam logic [4:0] CLASS_B = 5'h02;
    localparam logic [4:0] CLASS_C = 5'h04;
    localparam logic [4:0] CLASS_USABLE = 5'h07;

    localparam logic [7:0] TS_DIRECT = 8'h3b;
    localparam logic [7:0] TS_INVERSE = 8'h3f;
    localparam logic [3:0] PROT_GLOBAL = 4'hf;
    localparam logic [3:0] GLOBAL_MIN_GRP = 4'h3;

    // currents in units of 0.1 mA
    localparam logic [9:0] ATR_MAX_A = 10'h064;
    localparam logic [9:0] ATR_MAX_B = 10'h04b;
    localparam logic [9:0] ATR_MAX_C = 10'h032;
    localparam logic [9:0] SESS_MAX_A = 10'h258;
    localparam logic [9:0] SESS_MAX_B = 10'h1f4;
    localparam logic [9:0] SESS_MAX_C = 10'h12c;
    localparam logic [9:0] SESS_DEFAULT = 10'h064;

    typedef struct packed {
        logic valid;
        logic err;
        logic [7:0] data;
    } cvs_atr_byte_t;

    typedef struct packed {
        logic started;
        logic done;
        logic corrupt;
        logic cls_valid;
        logic [4:0] cls;
    } cvs_atr_info_t;

endpackage

// ### src/cvs_seq.sv
// Purpose: terminal-side supply class selection during card activation, plus power limit
// Assumes: an external receiver delivers answer-to-reset bytes on mclk_in
// Notes: classes D and E are never applied; long waits are parameters for simulation
`timescale 1ns/1ns
`default_nettype none
module cvs_seq #(
    parameter int PWR_SETTLE = cvs_pkg::PWR_SETTLE_CYC,
    parameter int RST_HOLD = cvs_pkg::RST_HOLD_CYC,
    parameter int ATR_WAIT = cvs_pkg::ATR_WAIT_CYC,
    parameter int DEACT_WAIT = cvs_pkg::DEACT_CYC
) (
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input wire logic start_in,
    input wire logic [4:0] term_classes_in,
    input wire cvs_pkg::cvs_atr_byte_t atr_byte_in,
    input wire logic app_select_in,
    input wire logic access_ok_in,
    input wire logic app_cmd_in,
    input wire logic power_ind_valid_in,
    input wire logic [9:0] power_ind_in,
    output logic vcc_en_out,
    output logic [4:0] vcc_class_out,
    output logic card_clk_en_out,
    output logic card_rst_n_out,
    output logic link_ready_out,
    output logic card_rejected_out,
    output logic [4:0] card_classes_out,
    output logic app_selected_out,
    output logic [9:0] current_limit_out
);
    import cvs_pkg::*;

    typedef enum {ST_IDLE, ST_POWER, ST_RESET, ST_WAIT_ATR, ST_DEACT, ST_READY,
                  ST_REJECT} cvs_state_t;

    // lowest usable class, reserved bits dropped
    function automatic logic [4:0] lowest_class(input logic [4:0] m);
        logic [4:0] u;
        u = m & CLASS_USABLE;
        if (u[2]) begin
            return CLASS_C;
        end else if (u[1]) begin
            return CLASS_B;
        end else if (u[0]) begin
            return CLASS_A;
        end
        return CLASS_NONE;
    endfunction

    // one step up in voltage, if the terminal has it
    function automatic logic [4:0] next_higher(input logic [4:0] c, input logic [4:0] m);
        logic [4:0] up;
        up = {1'b0, c[4:1]} & CLASS_USABLE;
        if ((up & m) != CLASS_NONE) begin
            return up;
        end
        return CLASS_NONE;
    endfunction

    // gaps in a card mask are refused
    function automatic logic contiguous(input logic [4:0] m);
        logic [4:0] low;
        low = m & (~m + 5'h01);
        return ((m + low) & m) == 5'h00;
    endfunction

    function automatic logic [9:0] atr_limit(input logic [4:0] c);
        case (c)
            CLASS_A: return ATR_MAX_A;
            CLASS_B: return ATR_MAX_B;
            default: return ATR_MAX_C;
        endcase
    endfunction

    function automatic logic [9:0] sess_limit(input logic [4:0] c);
        case (c)
            CLASS_A: return SESS_MAX_A;
            CLASS_B: return SESS_MAX_B;
            default: return SESS_MAX_C;
        endcase
    endfunction

    cvs_state_t state, next_state;
    logic [31:0] timer, next_timer;
    logic [4:0] cls, next_cls;
    logic [4:0] retry_cls, next_retry_cls;
    logic [1:0] corrupt_cnt, next_corrupt_cnt;
    logic escalated, next_escalated;
    logic first_class, next_first_class;
    logic switched, next_switched;
    logic rejected, next_rejected;
    logic [4:0] card_mask, next_card_mask;
    logic parse_clr, next_parse_clr;
    cvs_atr_info_t info;

    logic vcc_en, next_vcc_en;
    logic clk_en, next_clk_en;
    logic rst_n, next_rst_n;
    logic ready, next_ready;

    cvs_atr_parse u_parse (
        .mclk_in(mclk_in),
        .sys_rst_in(sys_rst_in),
        .clr_in(parse_clr),
        .byte_in(atr_byte_in),
        .info_out(info)
    );

    always_comb begin
        logic corrupt_now;
        logic [4:0] pick;
        corrupt_now = 1'b0;
        pick = CLASS_NONE;
        next_state = state;
        next_timer = (timer != 32'h0) ? timer - 32'h1 : 32'h0;
        next_cls = cls;
        next_retry_cls = retry_cls;
        next_corrupt_cnt = corrupt_cnt;
        next_escalated = escalated;
        next_first_class = first_class;
        next_switched = switched;
        next_rejected = rejected;
        next_card_mask = card_mask;
        next_parse_clr = 1'b0;
        next_vcc_en = vcc_en;
        next_clk_en = clk_en;
        next_rst_n = rst_n;
        next_ready = ready;
        case (state)
            ST_IDLE: begin
                if (start_in) begin
                    // start at the lowest class we have
                    next_cls = lowest_class(term_classes_in);
                    next_corrupt_cnt = 2'h0;
                    next_escalated = 1'b0;
                    next_first_class = 1'b1;
                    next_switched = 1'b0;
                    next_rejected = 1'b0;
                    next_ready = 1'b0;
                    next_card_mask = CLASS_NONE;
                    if (lowest_class(term_classes_in) == CLASS_NONE) begin
                        next_rejected = 1'b1;
                        next_state = ST_REJECT;
                    end else begin
                        next_vcc_en = 1'b1;
                        next_timer = PWR_SETTLE;
                        next_state = ST_POWER;
                    end
                end
            end
            ST_POWER: begin
                if (timer == 32'h0) begin
                    next_clk_en = 1'b1;
                    next_timer = RST_HOLD;
                    next_parse_clr = 1'b1;
                    next_state = ST_RESET;
                end
            end
            ST_RESET: begin
                if (timer == 32'h0) begin
                    // the first bytes after this edge are the answer
                    next_rst_n = 1'b1;
                    next_timer = ATR_WAIT;
                    next_state = ST_WAIT_ATR;
                end
            end
            ST_WAIT_ATR: begin
                corrupt_now = info.corrupt || (timer == 32'h0 && info.started && !info.done)
                              || (info.done && info.cls_valid && !contiguous(info.cls));
                if (corrupt_now) begin
                    // same class again until three bad answers
                    next_first_class = 1'b0;
                    next_retry_cls = cls;
                    next_corrupt_cnt = corrupt_cnt + 2'h1;
                    if (corrupt_cnt + 2'h1 >= 2'(CORRUPT_TRIES)) begin
                        // only the immediate next class, once
                        next_corrupt_cnt = 2'h0;
                        next_retry_cls = escalated ? CLASS_NONE
                                                   : next_higher(cls, term_classes_in);
                        next_escalated = 1'b1;
                    end
                    next_state = ST_DEACT;
                end else if (info.done) begin
                    next_corrupt_cnt = 2'h0;
                    // missing class byte: the card runs at the present class
                    next_card_mask = info.cls_valid ? info.cls : cls;
                    pick = lowest_class(info.cls & term_classes_in);
                    // move to a class the card indicates, only from the first class tried, else reject
                    if (info.cls_valid && (info.cls & cls) == CLASS_NONE) begin
                        next_retry_cls = (switched || !first_class) ? CLASS_NONE : pick;
                        next_switched = 1'b1;
                        next_first_class = 1'b0;
                        next_state = ST_DEACT;
                    end else begin
                        // other traffic allowed only from here
                        next_ready = 1'b1;
                        next_state = ST_READY;
                    end
                end else if (timer == 32'h0) begin
                    // silent card: step up one class
                    next_first_class = 1'b0;
                    next_corrupt_cnt = 2'h0;
                    next_retry_cls = next_higher(cls, term_classes_in);
                    next_state = ST_DEACT;
                end
                if (next_state == ST_DEACT) begin
                    next_rst_n = 1'b0;
                    next_clk_en = 1'b0;
                    next_vcc_en = 1'b0;
                    next_timer = DEACT_WAIT;
                end
            end
            ST_DEACT: begin
                if (timer == 32'h0) begin
                    if (retry_cls == CLASS_NONE) begin
                        next_rejected = 1'b1;
                        next_state = ST_REJECT;
                    end else begin
                        next_cls = retry_cls;
                        next_vcc_en = 1'b1;
                        next_timer = PWR_SETTLE;
                        next_state = ST_POWER;
                    end
                end
            end
            ST_READY: begin
                if (start_in) begin
                    // fresh activation needs the supply off first
                    next_ready = 1'b0;
                    next_rst_n = 1'b0;
                    next_clk_en = 1'b0;
                    next_vcc_en = 1'b0;
                    next_timer = DEACT_WAIT;
                    next_state = ST_IDLE;
                end
            end
            ST_REJECT: begin
                if (start_in) begin
                    next_state = ST_IDLE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
        // supply may only be re-raised once the off time has elapsed
        if (state == ST_IDLE && timer != 32'h0) begin
            next_state = ST_IDLE;
            next_vcc_en = 1'b0;
            next_cls = cls;
            next_rejected = rejected;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            state <= ST_IDLE;
            timer <= 32'h0;
            cls <= CLASS_NONE;
            retry_cls <= CLASS_NONE;
            corrupt_cnt <= 2'h0;
            escalated <= 1'b0;
            first_class <= 1'b0;
            switched <= 1'b0;
            rejected <= 1'b0;
            card_mask <= CLASS_NONE;
            parse_clr <= 1'b1;
            vcc_en <= 1'b0;
            clk_en <= 1'b0;
            rst_n <= 1'b0;
            ready <= 1'b0;
        end else begin
            state <= next_state;
            timer <= next_timer;
            cls <= next_cls;
            retry_cls <= next_retry_cls;
            corrupt_cnt <= next_corrupt_cnt;
            escalated <= next_escalated;
            first_class <= next_first_class;
            switched <= next_switched;
            rejected <= next_rejected;
            card_mask <= next_card_mask;
            parse_clr <= next_parse_clr;
            vcc_en <= next_vcc_en;
            clk_en <= next_clk_en;
            rst_n <= next_rst_n;
            ready <= next_ready;
        end
    end

    // power bookkeeping of the running application
    logic selected, next_selected;
    logic ind_seen, next_ind_seen;
    logic [9:0] ind, next_ind;
    logic [9:0] limit, next_limit;

    always_comb begin
        next_selected = selected;
        next_ind_seen = ind_seen;
        next_ind = ind;
        if (!ready) begin
            next_selected = 1'b0;
            next_ind_seen = 1'b0;
        end else begin
            if (app_select_in) begin
                next_selected = 1'b0;
                next_ind_seen = 1'b0;
            end
            // indication from select or status response
            if (power_ind_valid_in) begin
                next_ind_seen = 1'b1;
                next_ind = (power_ind_in > sess_limit(cls)) ? sess_limit(cls) : power_ind_in;
            end
            // only verification or a real command selects
            if (access_ok_in || app_cmd_in) begin
                next_selected = 1'b1;
            end
        end
        // default session figure when selected and nothing was indicated
        if (!next_selected) begin
            next_limit = atr_limit(next_cls);
        end else if (next_ind_seen) begin
            next_limit = next_ind;
        end else begin
            next_limit = SESS_DEFAULT;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            selected <= 1'b0;
            ind_seen <= 1'b0;
            ind <= 10'h000;
            limit <= ATR_MAX_C;
        end else begin
            selected <= next_selected;
            ind_seen <= next_ind_seen;
            ind <= next_ind;
            limit <= next_limit;
        end
    end

    assign vcc_en_out = vcc_en;
    assign vcc_class_out = cls;
    assign card_clk_en_out = clk_en;
    assign card_rst_n_out = rst_n;
    assign link_ready_out = ready;
    assign card_rejected_out = rejected;
    assign card_classes_out = card_mask;
    assign app_selected_out = selected;
    assign current_limit_out = limit;

endmodule
`default_nettype wire
